// ### rtl/fault_supervisor_pkg.sv
// Overview of operation
// RULE_01 - an overcurrent report turns the high-side switch off at once, holds it off for the overcurrent off-time, then lets it switch again.
// RULE_02 - the off-then-restart hiccup repeats while the overcurrent report persists and stops once the current is back under the limit.
// RULE_03 - an upper thermal report stops switching, cuts the output current and pulls the fault line low.
// RULE_04 - after thermal shutdown nothing restarts until the lower thermal comparator shows cooling, and the fault line is released on restart.
// RULE_05 - an overcurrent-type fault turns the switch off at once and retries switching after a 1 ms wait.
// RULE_06 - an overcurrent-type fault pulls the fault line low only on the second overcurrent cycle, never on the first.
// RULE_07 - after a shorted-inductor fault the fault line is released only after 10 ms with no overcurrent trigger.
// RULE_08 - after a shorted current-set resistor fault the same 10 ms free of overcurrent is needed before release.
// RULE_09 - feedback above 2 V turns the switch off at once and pulls the fault line low immediately.
// RULE_10 - after that open-resistor fault the fault line is released 10 ms after feedback falls below 1.55 V.
// RULE_11 - without dimming, averaged feedback below 0.2 V for a continuous 10 ms pulls the fault line low at the end of that interval.
// RULE_12 - the fault line is only ever actively pulled low or left undriven; the host supplies the pull-up.
// RULE_13 - after a low-feedback fault the fault line is released once averaged feedback has stayed at regulation level for 10 ms.
// RULE_14 - the fault line is held low while any one fault source is asserted, all sources ored together.
package fault_supervisor_pkg;

  // =====================================================================
  // timing
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned OCP_OFF_NS      = 1_000;
  localparam int unsigned RETRY_US        = 1_000;
  localparam int unsigned RECOVER_US      = 10_000;
  localparam int unsigned OCP_OFF_CYC     = (OCP_OFF_NS * (CLK_HZ / 1_000_000) + 999) / 1_000;
  localparam int unsigned RETRY_CYC       = RETRY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RECOVER_CYC     = RECOVER_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W           = 24;
  localparam int unsigned OC_REPORT_COUNT = 2;

  // =====================================================================
  // comparator bundle
  typedef struct packed {
    logic oc_above_limit;
    logic temp_above_upper;
    logic temp_above_lower;
    logic fb_above_open;
    logic fb_below_release;
    logic fb_avg_below_reg;
  } sense_t;

  typedef enum logic [1:0] {
    OC_IDLE,
    OC_OFF,
    OC_RETRY
  } oc_state_t;

endpackage

// ### rtl/fault_timer.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================================================
// counts cycles while run is high, clears when run drops
module fault_timer #(
  parameter int unsigned W     = 24,
  parameter int unsigned LIMIT = 1_250_000
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      done
);

  logic [W-1:0] count_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_r <= '0;
      done    <= 1'b0;
    end
    else if (!run)
    begin
      count_r <= '0;
      done    <= 1'b0;
    end
    else if (count_r >= W'(LIMIT - 1))
    begin
      done <= 1'b1;
    end
    else
    begin
      count_r <= count_r + W'(1);
      done    <= (count_r == W'(LIMIT - 2));
    end
  end

endmodule
`default_nettype wire

// ### rtl/fault_supervisor.sv
`timescale 1ns/100ps
`default_nettype none
module fault_supervisor #(
  parameter int unsigned OCP_OFF_CYC = fault_supervisor_pkg::OCP_OFF_CYC,
  parameter int unsigned RETRY_CYC   = fault_supervisor_pkg::RETRY_CYC,
  parameter int unsigned RECOVER_CYC = fault_supervisor_pkg::RECOVER_CYC
) (
  input  wire logic                         clk,
  input  wire logic                         resetn,
  input  wire fault_supervisor_pkg::sense_t sense,
  input  wire logic                         dimming_active,
  output logic                              switch_inhibit,
  output logic                              output_cut,
  output logic                              fault_report_line_o,
  output logic                              fault_report_line_oe
);

  localparam int unsigned W = fault_supervisor_pkg::CNT_W;

  // =====================================================================
  // reset release
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // =====================================================================
  // thermal shutdown with hysteresis
  logic thermal_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      thermal_r <= 1'b0;
    else if (sense.temp_above_upper)
      thermal_r <= 1'b1; // [RULE_03]
    else if (!sense.temp_above_lower)
      thermal_r <= 1'b0; // [RULE_04]
  end

  // =====================================================================
  // overcurrent hiccup sequencer
  fault_supervisor_pkg::oc_state_t oc_state_r;
  logic [W-1:0] oc_cnt_r;
  logic [1:0]   oc_events_r;
  logic         oc_fault_r;
  logic         oc_quiet_done;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oc_state_r <= fault_supervisor_pkg::OC_IDLE;
      oc_cnt_r   <= '0;
    end
    else
    begin
      case (oc_state_r)
        fault_supervisor_pkg::OC_IDLE:
        begin
          if (sense.oc_above_limit)
          begin
            oc_state_r <= fault_supervisor_pkg::OC_OFF; // [RULE_01]
            oc_cnt_r   <= '0;
          end
        end
        fault_supervisor_pkg::OC_OFF:
        begin
          // short off-time first; a second event escalates to the 1 ms retry wait
          if (oc_cnt_r >= W'(OCP_OFF_CYC - 1))
          begin
            oc_cnt_r   <= '0;
            oc_state_r <= (oc_events_r >= 2'(fault_supervisor_pkg::OC_REPORT_COUNT))
                          ? fault_supervisor_pkg::OC_RETRY
                                                : fault_supervisor_pkg::OC_IDLE; // [RULE_02]
          end
          else
            oc_cnt_r <= oc_cnt_r + W'(1);
        end
        fault_supervisor_pkg::OC_RETRY:
        begin
          if (oc_cnt_r >= W'(RETRY_CYC - 1))
          begin
            oc_cnt_r   <= '0;
            oc_state_r <= fault_supervisor_pkg::OC_IDLE; // [RULE_05]
          end
          else
            oc_cnt_r <= oc_cnt_r + W'(1);
        end
        default:
          oc_state_r <= fault_supervisor_pkg::OC_IDLE;
      endcase
    end
  end

  // event counter: fault reported from the second cycle on, never on the first
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      oc_events_r <= 2'd0;
    else if (oc_state_r == fault_supervisor_pkg::OC_IDLE && sense.oc_above_limit)
    begin
      if (oc_events_r != 2'd3)
        oc_events_r <= oc_events_r + 2'd1;
    end
    else if (oc_quiet_done)
      oc_events_r <= 2'd0; // [RULE_07] [RULE_08]
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      oc_fault_r <= 1'b0;
    else if (oc_state_r == fault_supervisor_pkg::OC_IDLE && sense.oc_above_limit
             && oc_events_r >= 2'(fault_supervisor_pkg::OC_REPORT_COUNT - 1))
      oc_fault_r <= 1'b1; // [RULE_06] [RULE_05]
    else if (oc_quiet_done)
      oc_fault_r <= 1'b0; // [RULE_07] [RULE_08]
  end

  // quiet window runs while switching normally with no overcurrent
  fault_timer #(.W(W), .LIMIT(RECOVER_CYC)) u_oc_quiet (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (oc_events_r != 2'd0 && oc_state_r == fault_supervisor_pkg::OC_IDLE
            && !sense.oc_above_limit),
    .done  (oc_quiet_done)
  );

  // =====================================================================
  // open current-set resistor (feedback too high)
  logic fb_open_r;
  logic fb_open_done;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fb_open_r <= 1'b0;
    else if (sense.fb_above_open)
      fb_open_r <= 1'b1; // [RULE_09]
    else if (fb_open_done)
      fb_open_r <= 1'b0; // [RULE_10]
  end

  fault_timer #(.W(W), .LIMIT(RECOVER_CYC)) u_fb_open (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (fb_open_r && sense.fb_below_release && !sense.fb_above_open),
    .done  (fb_open_done)
  );

  // =====================================================================
  // low feedback (open string), no dimming only
  logic fb_low_r;
  logic fb_low_set;
  logic fb_low_clr;

  fault_timer #(.W(W), .LIMIT(RECOVER_CYC)) u_fb_low_set (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (!fb_low_r && !dimming_active && sense.fb_avg_below_reg),
    .done  (fb_low_set)
  );

  fault_timer #(.W(W), .LIMIT(RECOVER_CYC)) u_fb_low_clr (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (fb_low_r && !sense.fb_avg_below_reg),
    .done  (fb_low_clr)
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fb_low_r <= 1'b0;
    else if (fb_low_set)
      fb_low_r <= 1'b1; // [RULE_11]
    else if (fb_low_clr)
      fb_low_r <= 1'b0; // [RULE_13]
  end

  // =====================================================================
  // outputs; combinational hazards on the inhibit path avoided by registering
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      switch_inhibit       <= 1'b1;
      output_cut           <= 1'b1;
      fault_report_line_o  <= 1'b0;
      fault_report_line_oe <= 1'b0;
    end
    else
    begin
      switch_inhibit <= sense.oc_above_limit || sense.fb_above_open
                        || oc_state_r != fault_supervisor_pkg::OC_IDLE
                        || thermal_r || sense.temp_above_upper || fb_open_r; // [RULE_01] [RULE_09]
      output_cut     <= thermal_r || sense.temp_above_upper; // [RULE_03]
      fault_report_line_o  <= 1'b0; // [RULE_12]
      fault_report_line_oe <= thermal_r || sense.temp_above_upper || oc_fault_r
                              || fb_open_r || sense.fb_above_open || fb_low_r; // [RULE_14]
    end
  end

endmodule
`default_nettype wire

// ### sim/fault_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================================================
// host side of the fault line: pull-up plus input buffer
module fault_host_model (
  input  wire logic fault_report_line_o,
  input  wire logic fault_report_line_oe,
  output logic      line_level
);
  // released line floats up to the host rail, never to the last driven value
  assign line_level = fault_report_line_oe ? fault_report_line_o : 1'b1;
endmodule
`default_nettype wire

// ### sim/fault_supervisor_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module fault_supervisor_monitor #(
  parameter int unsigned OCP_OFF_CYC = 4,
  parameter int unsigned RETRY_CYC   = 20,
  parameter int unsigned RECOVER_CYC = 50
) (
  input wire logic                         clk,
  input wire logic                         resetn,
  input wire fault_supervisor_pkg::sense_t sense,
  input wire logic                         dimming_active,
  input wire logic                         switch_inhibit,
  input wire logic                         output_cut,
  input wire logic                         fault_report_line_o,
  input wire logic                         fault_report_line_oe
);
  // =====================================================================
  // helpers: skip the internal reset copy before judging outputs
  localparam int STUCK_MAX = OCP_OFF_CYC + RETRY_CYC + RECOVER_CYC + 4;
  logic [2:0]  up_r;
  logic [23:0] stuck_r;
  logic        rdy;
  logic        quiet;
  assign rdy   = (up_r == 3'h7);
  assign quiet = !sense.oc_above_limit && !sense.temp_above_upper &&
                 !sense.temp_above_lower && !sense.fb_above_open && sense.fb_below_release;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      up_r <= 3'h0;
    else if (!rdy)
      up_r <= up_r + 3'h1;
  end
  // counts how long the switch stays off with no cause left
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      stuck_r <= 24'h0;
    else
      stuck_r <= (rdy && switch_inhibit && quiet) ? stuck_r + 24'h1 : 24'h0;
  end
  // =====================================================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_oc_off; rdy && sense.oc_above_limit |=> switch_inhibit; endproperty
  a_oc_off: assert property (p_oc_off) else $error("switch on after overcurrent");
  property p_stuck; stuck_r <= STUCK_MAX; endproperty
  a_stuck: assert property (p_stuck) else $error("hiccup never ends");
  property p_hot;
    rdy && sense.temp_above_upper |=> switch_inhibit && output_cut && fault_report_line_oe;
  endproperty
  a_hot: assert property (p_hot) else $error("no thermal shutdown");
  // cut may be the tail of a shutdown already ended; only a lower report held a cycle proves it
  property p_cooling;
    rdy && output_cut && sense.temp_above_lower && $past(sense.temp_above_lower) |=> output_cut;
  endproperty
  a_cooling: assert property (p_cooling) else $error("restart before cooling");
  // the latched state clears one edge after cooling, the registered cut one edge later
  property p_cool;
    rdy && output_cut && !sense.temp_above_lower && !sense.temp_above_upper
    |=> ##1 (!output_cut || $past(sense.temp_above_upper));
  endproperty
  a_cool: assert property (p_cool) else $error("no restart after cooling");
  property p_open;
    rdy && sense.fb_above_open |=> switch_inhibit && fault_report_line_oe;
  endproperty
  a_open: assert property (p_open) else $error("open feedback not reported");
  property p_low; fault_report_line_o == 1'b0; endproperty
  a_low: assert property (p_low) else $error("fault line driven high");
  property p_any;
    rdy && fault_report_line_oe && (sense.temp_above_upper || sense.fb_above_open)
    |=> fault_report_line_oe;
  endproperty
  a_any: assert property (p_any) else $error("fault line released with a source on");
  c_oc: cover property (rdy && sense.oc_above_limit);
  c_hot: cover property (rdy && output_cut && sense.temp_above_lower);
  c_fbl: cover property (rdy && !dimming_active && sense.fb_avg_below_reg && fault_report_line_oe);
endmodule
bind fault_supervisor fault_supervisor_monitor #(
  .OCP_OFF_CYC(OCP_OFF_CYC), .RETRY_CYC(RETRY_CYC), .RECOVER_CYC(RECOVER_CYC)
) fault_supervisor_monitor_i (
  .clk(clk), .resetn(resetn), .sense(sense), .dimming_active(dimming_active),
  .switch_inhibit(switch_inhibit), .output_cut(output_cut),
  .fault_report_line_o(fault_report_line_o), .fault_report_line_oe(fault_report_line_oe)
);
`default_nettype wire

// ### sim/fault_supervisor_bench.sv
`timescale 1ns/100ps
`default_nettype none
module fault_supervisor_bench;
  // short counts keep the run small; expectations derive from these
  localparam int OFF = 4;
  localparam int RTY = 20;
  localparam int REC = 50;
  localparam int LIMIT = 2000;
  logic                         clk = 1'b0;
  logic                         resetn = 1'b0;
  fault_supervisor_pkg::sense_t s = 6'h02;
  logic                         dim = 1'b0;
  logic                         inh;
  logic                         cut;
  logic                         fo;
  logic                         foe;
  logic                         line;
  int                           n_errors = 0;
  int                           checked = 0;
  int                           cycles = 0;
  int                           hold;
  always #4 clk = ~clk;
  fault_supervisor #(.OCP_OFF_CYC(OFF), .RETRY_CYC(RTY), .RECOVER_CYC(REC)) fault_supervisor_i (
    .clk(clk), .resetn(resetn), .sense(s), .dimming_active(dim), .switch_inhibit(inh),
    .output_cut(cut), .fault_report_line_o(fo), .fault_report_line_oe(foe));
  fault_host_model fault_host_model_i (
    .fault_report_line_o(fo), .fault_report_line_oe(foe), .line_level(line));
  // =====================================================================
  // compare and report
  task automatic chk(input logic got, input int exp, input string what);
    if (exp >= 0)
    begin
      checked++;
      if (got !== exp[0])
      begin
        n_errors++;
        $display("ERROR %0t %s is %b", $time, what, got);
      end
    end
  endtask
  // expected levels from the model: -1 leaves a signal unchecked
  task automatic look(input int n, input int ei, input int ec, input int eo);
    repeat (n) @(posedge clk);
    #1;
    chk(inh, ei, "inhibit");
    chk(cut, ec, "cut");
    chk(foe, eo, "fault drive");
    chk(line, eo < 0 ? -1 : 1 - eo, "fault line");
  endtask
  task automatic conclude;
    if (n_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      n_errors = n_errors + 1;
      conclude;
    end
  end
  // =====================================================================
  // scenarios
  initial
  begin
    void'($urandom(32'h6178ac47));
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    look(8, 0, 0, 0);
    @(posedge clk) s.oc_above_limit <= 1'b1;
    @(posedge clk) s.oc_above_limit <= 1'b0;
    look(0, 1, 0, 0);
    look(OFF + 3, 0, 0, 0);
    @(posedge clk) s.oc_above_limit <= 1'b1;
    look(4, 1, 0, 1);
    look(26, 1, 0, 1);
    @(posedge clk) s.oc_above_limit <= 1'b0;
    look(10, 1, 0, 1);
    look(42, 0, 0, 1);
    look(30, 0, 0, 0);
    @(posedge clk);
    s.temp_above_upper <= 1'b1;
    s.temp_above_lower <= 1'b1;
    look(2, 1, 1, 1);
    @(posedge clk) s.temp_above_upper <= 1'b0;
    look(10, 1, 1, 1);
    @(posedge clk) s.temp_above_lower <= 1'b0;
    look(2, 0, 0, 0);
    @(posedge clk);
    s.fb_above_open <= 1'b1;
    s.fb_below_release <= 1'b0;
    dim <= 1'($urandom_range(1, 0));
    look(2, 1, 0, 1);
    @(posedge clk) s.fb_above_open <= 1'b0;
    hold = $urandom_range(60, 20);
    look(hold, -1, 0, 1);
    @(posedge clk);
    s.temp_above_upper <= 1'b1;
    s.temp_above_lower <= 1'b1;
    look(2, 1, 1, 1);
    @(posedge clk);
    s.temp_above_upper <= 1'b0;
    s.temp_above_lower <= 1'b0;
    look(3, -1, 0, 1);
    @(posedge clk) s.fb_below_release <= 1'b1;
    look(REC - 5, -1, 0, 1);
    look(10, 0, 0, 0);
    @(posedge clk);
    dim <= 1'b1;
    s.fb_avg_below_reg <= 1'b1;
    look(REC + 10, -1, 0, 0);
    @(posedge clk) dim <= 1'b0;
    look(REC - 5, -1, 0, 0);
    look(10, -1, 0, 1);
    @(posedge clk) s.fb_avg_below_reg <= 1'b0;
    look(REC - 5, -1, 0, 1);
    look(10, 0, 0, 0);
    conclude;
  end
endmodule
`default_nettype wire
